// ==== hw/dds_sequencer.sv ====
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
// Functional notes
// - loop-decrement done, count nonzero: decrement, refetch chain target
// - loop count zero, chaining set: fetch descriptor after the loop
// - sync descriptor moves no data; only sets, clears or waits
// - sync descriptor never decrements the repeat counter
// - wait sync stalls until masked trigger bits equal compare value
// - set/clear sync applies set mask and clear mask to trigger bits
// - after transfer, address registers hold last address moved
// - address mode 0 loads absolute address, 1 adds offset to current
// - chain word: bit 0 enable, bit 1 relative, upper bits address
// - relative chain adds signed offset to current descriptor address
// - write-immediate descriptor loads the repeat counter
// - chained completion fetches the next descriptor automatically
// - done-flag enable raises the done flag even when chaining continues
// - unchained completion with no loop pending stops channel and always raises the done flag
// - fetch trigger starts fetch at the channel chain address
// - looping descriptor is refetched from memory every iteration
// - trigger bits set/cleared by sync descriptors and software; event inputs only set them
// - descriptors are 16 bytes; relative offset 0x10 is the next one
module dds_sequencer
	import dds_pkg::*;
(
	input wire logic REF_CLK,
	input wire logic RESETN,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	output dds_mem_req_s MEM_REQ,
	input wire logic MEM_ACK,
	input wire logic [31:0] MEM_RDATA,
	input wire logic [7:0] EVENT_SET,
	output logic DONE_FLAG,
	output logic BUSY,
	output logic [7:0] TRIGGER_BITS
);
	dds_state_s s_reg;
	dds_state_s s_next;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] next_addr(input logic rel,
		input logic [31:0] cur, input logic [31:0] val);
		next_addr = rel ? cur + val : val;
	endfunction
	function automatic logic [31:0] chain_target(input logic [31:0] cw,
		input logic [31:0] cur);
		logic [31:0] off;
		off = {cw[31:2], 2'b00};
		chain_target = next_addr(cw[DDS_CHAIN_REL_BIT], cur, off);
	endfunction
	wire logic sw_wr_trig = WR && ADDR == DDS_OFF_TRIG;
	wire logic [1:0] dtype = s_reg.desc.ctrl[1:0];
	wire logic chained = s_reg.desc.chain[DDS_CHAIN_EN_BIT];
	wire logic [7:0] cmp_mask = s_reg.desc.dst[15:8];
	wire logic [7:0] cmp_val = s_reg.desc.dst[7:0];
	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb
	begin
		logic [7:0] evt_rise;
		logic fin;
		logic loop_again;
		evt_rise = s_reg.evt_sync2 & s_reg.trig_en;
		fin = 1'b0;
		// a pending loop refetches even with chaining off
		loop_again = s_reg.desc.ctrl[DDS_CW_LOOP_DEC_BIT]
			&& dtype == DDS_TYPE_XFER && s_reg.repeat_cnt != DDS_RESET_BYTE;
		s_next = s_reg;
		s_next.evt_sync1 = EVENT_SET;
		s_next.evt_sync2 = s_reg.evt_sync1;
		s_next.trig = s_reg.trig | evt_rise;
		s_next.rdata = 32'h0000_0000;
		if (RD)
		begin
			case (ADDR)
				DDS_OFF_STATUS: s_next.rdata = {30'h0000_0000, s_reg.busy,
					s_reg.done_flag};
				DDS_OFF_TRIG: s_next.rdata = {24'h00_0000, s_reg.trig};
				DDS_OFF_REPEAT: s_next.rdata = {24'h00_0000, s_reg.repeat_cnt};
				DDS_OFF_CHAIN: s_next.rdata = s_reg.desc.chain;
				DDS_OFF_SRC: s_next.rdata = s_reg.src_addr;
				DDS_OFF_DST: s_next.rdata = s_reg.dst_addr;
				DDS_OFF_DESC: s_next.rdata = s_reg.desc_addr;
				DDS_OFF_TRIG_EN: s_next.rdata = {24'h00_0000, s_reg.trig_en};
				default: s_next.rdata = 32'h0000_0000;
			endcase
		end
		if (WR)
		begin
			case (ADDR)
				DDS_OFF_TRIG: s_next.trig = WDATA[7:0] | evt_rise;
				DDS_OFF_REPEAT: s_next.repeat_cnt = WDATA[7:0];
				DDS_OFF_CHAIN: if (!s_reg.busy) s_next.desc.chain = WDATA;
				DDS_OFF_TRIG_EN: s_next.trig_en = WDATA[7:0];
				default: ;
			endcase
		end
		case (s_reg.state)
			DDS_IDLE:
			begin
				// start only from idle; a trigger while busy is ignored
				if (WR && ADDR == DDS_OFF_CTRL && WDATA[DDS_CTRL_START_BIT])
				begin
					s_next.desc_addr = chain_target(s_reg.desc.chain,
						s_reg.desc_addr);
					s_next.word_idx = 2'h0;
					s_next.busy = 1'b1;
					s_next.mem.req = 1'b1;
					s_next.mem.we = 1'b0;
					s_next.mem.addr = s_next.desc_addr;
					s_next.state = DDS_FETCH;
				end
			end
			DDS_FETCH:
			begin
				if (MEM_ACK)
				begin
					// word order control, source, destination, chain
					case (s_reg.word_idx)
						2'h0: s_next.desc.ctrl = MEM_RDATA;
						2'h1: s_next.desc.src = MEM_RDATA;
						2'h2: s_next.desc.dst = MEM_RDATA;
						default: s_next.desc.chain = MEM_RDATA;
					endcase
					s_next.word_idx = s_reg.word_idx + 2'h1;
					s_next.mem.addr = s_reg.mem.addr + DDS_WORD_BYTES;
					if (s_reg.word_idx == DDS_LAST_WORD)
					begin
						s_next.mem.req = 1'b0;
						s_next.state = DDS_DECODE;
					end
				end
			end
			DDS_DECODE:
			begin
				case (dtype)
					DDS_TYPE_XFER:
					begin
						// first unit moves at the new address
						s_next.src_addr = next_addr(
							s_reg.desc.ctrl[DDS_CW_SRC_MODE_BIT],
							s_reg.src_addr, s_reg.desc.src);
						s_next.dst_addr = next_addr(
							s_reg.desc.ctrl[DDS_CW_DST_MODE_BIT],
							s_reg.dst_addr, s_reg.desc.dst);
						s_next.units_left = s_reg.desc.ctrl[DDS_CW_CNT_LSB +:
							DDS_CW_CNT_W];
						s_next.mem.req = 1'b1;
						s_next.mem.we = 1'b0;
						s_next.mem.addr = s_next.src_addr;
						s_next.state = DDS_READ;
					end
					DDS_TYPE_SYNC:
					begin
						// no bus traffic for sync descriptors
						s_next.trig = (s_next.trig & ~s_reg.desc.src[15:8])
							| s_reg.desc.src[7:0];
						s_next.state = DDS_WAIT;
					end
					DDS_TYPE_WRITE:
					begin
						s_next.repeat_cnt = s_reg.desc.src[7:0];
						fin = 1'b1;
					end
					default: fin = 1'b1;
				endcase
			end
			DDS_READ:
			begin
				if (MEM_ACK)
				begin
					s_next.data = MEM_RDATA;
					s_next.mem.we = 1'b1;
					s_next.mem.addr = s_reg.dst_addr;
					s_next.mem.wdata = MEM_RDATA;
					s_next.state = DDS_WRITE;
				end
			end
			DDS_WRITE:
			begin
				if (MEM_ACK)
				begin
					s_next.units_left = s_reg.units_left - 11'h001;
					if (s_reg.units_left == 11'h000)
					begin
						// last unit: registers keep the last address moved
						s_next.mem.req = 1'b0;
						fin = 1'b1;
					end
					else
					begin
						s_next.src_addr = s_reg.src_addr + DDS_WORD_BYTES;
						s_next.dst_addr = s_reg.dst_addr + DDS_WORD_BYTES;
						s_next.mem.we = 1'b0;
						s_next.mem.addr = s_reg.src_addr + DDS_WORD_BYTES;
						s_next.state = DDS_READ;
					end
				end
			end
			DDS_WAIT:
			begin
				if (((s_reg.trig ^ cmp_val) & cmp_mask) == DDS_RESET_BYTE)
					fin = 1'b1;
			end
			DDS_DONE: s_next.state = DDS_IDLE;
			default: s_next.state = DDS_IDLE;
		endcase
		// completion: loop, chain or stop
		if (fin)
		begin
			if (s_reg.desc.ctrl[DDS_CW_DONE_EN_BIT]
				|| !(chained || loop_again))
				s_next.done_flag = 1'b1;
			if (loop_again)
			begin
				s_next.repeat_cnt = s_reg.repeat_cnt - 8'h01;
				s_next.desc_addr = chain_target(s_reg.desc.chain,
					s_reg.desc_addr);
			end
			else if (s_reg.desc.ctrl[DDS_CW_LOOP_DEC_BIT]
				&& dtype == DDS_TYPE_XFER)
				s_next.desc_addr = s_reg.desc_addr + DDS_DESC_BYTES;
			else
				s_next.desc_addr = chain_target(s_reg.desc.chain,
					s_reg.desc_addr);
			if (chained || loop_again)
			begin
				s_next.word_idx = 2'h0;
				s_next.mem.req = 1'b1;
				s_next.mem.we = 1'b0;
				s_next.mem.addr = s_next.desc_addr;
				s_next.state = DDS_FETCH;
			end
			else
			begin
				s_next.mem.req = 1'b0;
				s_next.busy = 1'b0;
				s_next.state = DDS_DONE;
			end
		end
		// hardware set wins over a software clear in the same cycle
		if (WR && ADDR == DDS_OFF_CTRL && WDATA[DDS_CTRL_DONE_CLR_BIT] && !fin)
			s_next.done_flag = 1'b0;
	end
	always_ff @(posedge REF_CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			s_reg <= '0;
			s_reg.state <= DDS_IDLE;
		end
		else
			s_reg <= s_next;
	end
	assign RDATA = s_reg.rdata;
	assign MEM_REQ = s_reg.mem;
	assign DONE_FLAG = s_reg.done_flag;
	assign BUSY = s_reg.busy;
	assign TRIGGER_BITS = s_reg.trig;
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_sync_no_bus;
		@(posedge REF_CLK) disable iff (!RESETN)
		s_reg.state == DDS_WAIT |-> !s_reg.mem.req;
	endproperty
	a_sync_no_bus: assert property (p_sync_no_bus)
		else $error("bus active during sync");
	property p_sync_keeps_count;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_WAIT && !WR) |=> $stable(s_reg.repeat_cnt);
	endproperty
	a_sync_keeps_count: assert property (p_sync_keeps_count)
		else $error("sync changed repeat count");
	property p_wait_holds;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_WAIT
			&& ((s_reg.trig ^ cmp_val) & cmp_mask) != 8'h00)
		|=> s_reg.state == DDS_WAIT;
	endproperty
	a_wait_holds: assert property (p_wait_holds)
		else $error("wait left without match");
	sequence s_enter_done;
		s_reg.state != DDS_DONE ##1 s_reg.state == DDS_DONE;
	endsequence
	property p_stop_flag;
		@(posedge REF_CLK) disable iff (!RESETN)
		s_enter_done |-> s_reg.done_flag;
	endproperty
	a_stop_flag: assert property (p_stop_flag)
		else $error("stop without done flag");
	sequence s_start;
		s_reg.state == DDS_IDLE && WR && ADDR == DDS_OFF_CTRL
			&& WDATA[DDS_CTRL_START_BIT];
	endsequence
	property p_start_fetch;
		@(posedge REF_CLK) disable iff (!RESETN)
		s_start |=> s_reg.state == DDS_FETCH && s_reg.mem.req && s_reg.busy;
	endproperty
	a_start_fetch: assert property (p_start_fetch)
		else $error("start did not fetch");
	property p_fetch_order;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_FETCH && MEM_ACK && s_reg.word_idx == 2'h0)
		|=> s_reg.desc.ctrl == $past(MEM_RDATA) && s_reg.word_idx == 2'h1;
	endproperty
	a_fetch_order: assert property (p_fetch_order)
		else $error("control word not first");
	property p_sw_read;
		@(posedge REF_CLK) disable iff (!RESETN)
		(RD && ADDR == DDS_OFF_REPEAT)
		|=> RDATA[7:0] == $past(s_reg.repeat_cnt);
	endproperty
	a_sw_read: assert property (p_sw_read)
		else $error("repeat read wrong");
	property p_trig_write;
		@(posedge REF_CLK) disable iff (!RESETN)
		(sw_wr_trig && s_reg.state != DDS_DECODE) |=>
			(TRIGGER_BITS & $past(WDATA[7:0])) == $past(WDATA[7:0]);
	endproperty
	a_trig_write: assert property (p_trig_write)
		else $error("software trigger write lost");
	sequence s_loop_end;
		s_reg.state == DDS_WRITE && MEM_ACK && s_reg.units_left == 11'h000
			&& s_reg.desc.ctrl[DDS_CW_LOOP_DEC_BIT]
			&& s_reg.repeat_cnt != DDS_RESET_BYTE;
	endsequence
	property p_loop_back;
		@(posedge REF_CLK) disable iff (!RESETN)
		s_loop_end |=> s_reg.state == DDS_FETCH
			&& s_reg.repeat_cnt == $past(s_reg.repeat_cnt) - 8'h01;
	endproperty
	a_loop_back: assert property (p_loop_back)
		else $error("loop did not refetch");
	property p_loop_exit;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_WRITE && MEM_ACK && s_reg.units_left == 11'h000
			&& s_reg.desc.ctrl[DDS_CW_LOOP_DEC_BIT] && chained
			&& s_reg.repeat_cnt == DDS_RESET_BYTE)
		|=> s_reg.desc_addr == $past(s_reg.desc_addr) + DDS_DESC_BYTES;
	endproperty
	a_loop_exit: assert property (p_loop_exit)
		else $error("loop exit not sequential");
	property p_done_enable;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_WRITE && MEM_ACK && s_reg.units_left == 11'h000
			&& s_reg.desc.ctrl[DDS_CW_DONE_EN_BIT]) |=> s_reg.done_flag;
	endproperty
	a_done_enable: assert property (p_done_enable)
		else $error("done enable ignored");
	property p_write_imm;
		@(posedge REF_CLK) disable iff (!RESETN)
		(s_reg.state == DDS_DECODE && dtype == DDS_TYPE_WRITE)
		|=> s_reg.repeat_cnt == $past(s_reg.desc.src[7:0]);
	endproperty
	a_write_imm: assert property (p_write_imm)
		else $error("write-immediate lost");
endmodule

// ==== pkg/dds_pkg.sv ====
package dds_pkg;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] DDS_OFF_CTRL = 8'h00;
	localparam logic [7:0] DDS_OFF_STATUS = 8'h04;
	localparam logic [7:0] DDS_OFF_TRIG = 8'h08;
	localparam logic [7:0] DDS_OFF_REPEAT = 8'h0C;
	localparam logic [7:0] DDS_OFF_CHAIN = 8'h10;
	localparam logic [7:0] DDS_OFF_SRC = 8'h14;
	localparam logic [7:0] DDS_OFF_DST = 8'h18;
	localparam logic [7:0] DDS_OFF_DESC = 8'h1C;
	localparam logic [7:0] DDS_OFF_TRIG_EN = 8'h20;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int DDS_CTRL_START_BIT = 0;
	localparam int DDS_CTRL_DONE_CLR_BIT = 1;
	localparam int DDS_CHAIN_EN_BIT = 0;
	localparam int DDS_CHAIN_REL_BIT = 1;
	localparam int DDS_CW_DONE_EN_BIT = 15;
	localparam int DDS_CW_SRC_MODE_BIT = 16;
	localparam int DDS_CW_DST_MODE_BIT = 17;
	localparam int DDS_CW_LOOP_DEC_BIT = 18;
	localparam int DDS_CW_CNT_LSB = 4;
	localparam int DDS_CW_CNT_W = 11;
	// descriptor type codes in control word bits 1:0
	localparam logic [1:0] DDS_TYPE_XFER = 2'h0;
	localparam logic [1:0] DDS_TYPE_SYNC = 2'h1;
	localparam logic [1:0] DDS_TYPE_WRITE = 2'h2;
	localparam logic [31:0] DDS_DESC_BYTES = 32'h0000_0010;
	localparam logic [31:0] DDS_WORD_BYTES = 32'h0000_0004;
	localparam logic [1:0] DDS_LAST_WORD = 2'h3;
	localparam logic [7:0] DDS_RESET_BYTE = 8'h00;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [6:0]
	{
		DDS_IDLE = 7'b000_0001,
		DDS_FETCH = 7'b000_0010,
		DDS_DECODE = 7'b000_0100,
		DDS_READ = 7'b000_1000,
		DDS_WRITE = 7'b001_0000,
		DDS_WAIT = 7'b010_0000,
		DDS_DONE = 7'b100_0000
	} dds_state_e;
	typedef struct packed
	{
		logic req;
		logic we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} dds_mem_req_s;
	typedef struct packed
	{
		logic [31:0] ctrl;
		logic [31:0] src;
		logic [31:0] dst;
		logic [31:0] chain;
	} dds_desc_s;
	typedef struct packed
	{
		dds_state_e state;
		dds_desc_s desc;
		logic [1:0] word_idx;
		logic [31:0] desc_addr;
		logic [31:0] src_addr;
		logic [31:0] dst_addr;
		logic [31:0] data;
		logic [10:0] units_left;
		logic [7:0] repeat_cnt;
		logic [7:0] trig;
		logic [7:0] trig_en;
		logic done_flag;
		logic busy;
		dds_mem_req_s mem;
		logic [31:0] rdata;
		logic [7:0] evt_sync1;
		logic [7:0] evt_sync2;
	} dds_state_s;
endpackage

// ==== verif/dds_mem_model.sv ====
`timescale 1ns/10ps
module dds_mem_model
	import dds_pkg::*;
(
	input wire logic clk,
	input wire logic [3:0] ack_delay,
	input wire logic [31:0] probe_addr,
	input dds_mem_req_s req,
	output logic ack,
	output logic [31:0] rdata,
	output int probe_cnt,
	output int wr_cnt
);
	logic [31:0] words [0:511];
	logic [31:0] last;
	logic [3:0] cnt;
	// ----
	// bus side
	// ----
	assign ack = req.req && cnt == ack_delay;
	// idle bus shows inverse of previous cycle's rdata, so a stale word returns every other cycle
	assign rdata = (ack && !req.we) ? words[req.addr[10:2]] : ~last;
	initial
	begin
		cnt = 4'h0;
		last = 32'h0000_0000;
		probe_cnt = 0;
		wr_cnt = 0;
		for (int i = 0; i < 512; i++)
			words[i] = 32'hA5A5_0000 | (i << 2);
	end
	always @(posedge clk)
	begin
		cnt <= (ack || !req.req) ? 4'h0 : cnt + 4'h1;
		last <= rdata;
		if (ack && req.we)
		begin
			words[req.addr[10:2]] <= req.wdata;
			wr_cnt <= wr_cnt + 1;
		end
		if (ack && !req.we && req.addr == probe_addr)
			probe_cnt <= probe_cnt + 1;
	end
endmodule

// ==== verif/dds_sequencer_bench.sv ====
`timescale 1ns/10ps
module dds_sequencer_bench
	import dds_pkg::*;
;
	logic REF_CLK, RESETN, WR, RD, MEM_ACK, DONE_FLAG, BUSY, early;
	logic [7:0] ADDR, EVENT_SET, TRIGGER_BITS;
	logic [31:0] WDATA, RDATA, MEM_RDATA;
	logic [3:0] ack_delay;
	dds_mem_req_s MEM_REQ;
	int err_count = 0;
	int checks = 0;
	int cycles = 0;
	int probe_cnt, wr_cnt, n0, p0;
	dds_sequencer dut (.REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .MEM_REQ(MEM_REQ),
		.MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA), .EVENT_SET(EVENT_SET),
		.DONE_FLAG(DONE_FLAG), .BUSY(BUSY), .TRIGGER_BITS(TRIGGER_BITS));
	dds_mem_model memm (.clk(REF_CLK), .ack_delay(ack_delay),
		.probe_addr(32'h0000_0110), .req(MEM_REQ), .ack(MEM_ACK),
		.rdata(MEM_RDATA), .probe_cnt(probe_cnt), .wr_cnt(wr_cnt));
	// ----
	// helpers
	// ----
	task automatic tally_and_finish;
		if (err_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		checks++;
		if (s !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge REF_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge REF_CLK);
		WR <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, string nm);
		@(posedge REF_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge REF_CLK);
		RD <= 1'b0;
		#1;
		chk(nm, RDATA, e);
	endtask
	function automatic logic [31:0] pat(input logic [31:0] a);
		return 32'hA5A5_0000 | a;
	endfunction
	function automatic logic [31:0] m(input logic [31:0] a);
		return memm.words[a / 4];
	endfunction
	task automatic dsc(input logic [31:0] a, c, s, d, l);
		memm.words[a / 4] = c;
		memm.words[a / 4 + 1] = s;
		memm.words[a / 4 + 2] = d;
		memm.words[a / 4 + 3] = l;
	endtask
	task automatic start(input logic [31:0] a);
		n0 = wr_cnt;
		p0 = probe_cnt;
		wr(DDS_OFF_CTRL, 32'h0000_0002);
		wr(DDS_OFF_CHAIN, a | 32'h0000_0001);
		wr(DDS_OFF_CTRL, 32'h0000_0001);
	endtask
	task automatic wait_idle;
		early = 1'b0;
		for (int i = 0; i < 3000 && !(BUSY === 1'b0 && DONE_FLAG === 1'b1); i++)
		begin
			@(posedge REF_CLK);
			#1;
			if (DONE_FLAG === 1'b1 && BUSY === 1'b1)
				early = 1'b1;
		end
		chk("idle", {BUSY, DONE_FLAG}, 32'h0000_0001);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		rd(DDS_OFF_STATUS, 32'h0000_0000, "status");
		rd(DDS_OFF_TRIG, 32'h0000_0000, "trig");
		wr(8'h24, 32'hFFFF_FFFF);
		rd(8'h24, 32'h0000_0000, "unmapped");
	endtask
	task automatic t_link;
		dsc(32'h0000_0000, 32'h0000_0010, 32'h0000_0400,
			32'h0000_0500, 32'h0000_0013);
		dsc(32'h0000_0010, 32'h0003_0000, 32'h0000_0010,
			32'h0000_0020, 32'h0000_0043);
		dsc(32'h0000_0050, 32'h0000_0000, 32'h0000_0408,
			32'h0000_0508, 32'hFFFF_FFF3);
		dsc(32'h0000_0040, 32'h0003_0000, 32'h0000_0004,
			32'h0000_0004, 32'h0000_0000);
		start(32'h0000_0000);
		wait_idle();
		chk("w500", m(32'h0000_0500), pat(32'h0000_0400));
		chk("w504", m(32'h0000_0504), pat(32'h0000_0404));
		chk("w524", m(32'h0000_0524), pat(32'h0000_0414));
		chk("w508", m(32'h0000_0508), pat(32'h0000_0408));
		chk("w50c", m(32'h0000_050C), pat(32'h0000_040C));
		chk("writes", wr_cnt - n0, 32'h0000_0005);
		rd(DDS_OFF_SRC, 32'h0000_040C, "src");
		rd(DDS_OFF_DST, 32'h0000_050C, "dst");
		rd(DDS_OFF_STATUS, 32'h0000_0001, "status");
	endtask
	task automatic t_loop;
		ack_delay <= 4'h3;
		dsc(32'h0000_0100, 32'h0000_0002, 32'h0000_0002,
			32'h0000_0000, 32'h0000_0013);
		dsc(32'h0000_0110, 32'h0006_8000, 32'h0000_0410,
			32'h0000_0004, 32'h0000_0111);
		dsc(32'h0000_0120, 32'h0000_0001, 32'h0000_0080,
			32'h0000_0000, 32'h0000_0000);
		start(32'h0000_0100);
		wait_idle();
		for (int i = 0; i < 3; i++)
			chk("loop", m(32'h0000_0510 + 4 * i), pat(32'h0000_0410));
		chk("w51c", m(32'h0000_051C), pat(32'h0000_051C));
		chk("refetch", probe_cnt - p0, 32'h0000_0003);
		chk("early", early, 1'b1);
		rd(DDS_OFF_REPEAT, 32'h0000_0000, "repeat");
		rd(DDS_OFF_TRIG, 32'h0000_0080, "trig");
		ack_delay <= 4'h0;
	endtask
	task automatic t_sync;
		dsc(32'h0000_0180, 32'h0004_0001, 32'h0000_0000,
			32'h0000_8080, 32'h0000_0013);
		dsc(32'h0000_0190, 32'h0004_0001, 32'h0000_8001,
			32'h0000_0000, 32'h0000_0000);
		wr(DDS_OFF_REPEAT, 32'h0000_0005);
		wr(DDS_OFF_TRIG, 32'h0000_0000);
		start(32'h0000_0180);
		repeat (60) @(posedge REF_CLK);
		#1;
		chk("stall", BUSY, 1'b1);
		wr(DDS_OFF_TRIG, 32'h0000_0080);
		wait_idle();
		rd(DDS_OFF_TRIG, 32'h0000_0001, "trig");
		rd(DDS_OFF_REPEAT, 32'h0000_0005, "repeat");
		chk("writes", wr_cnt - n0, 32'h0000_0000);
	endtask
	task automatic t_event;
		wr(DDS_OFF_TRIG_EN, 32'h0000_0004);
		EVENT_SET <= 8'h0C;
		repeat (6) @(posedge REF_CLK);
		EVENT_SET <= 8'h00;
		repeat (4) @(posedge REF_CLK);
		rd(DDS_OFF_TRIG, 32'h0000_0005, "event");
		chk("trig_out", TRIGGER_BITS, 32'h0000_0005);
	endtask
	task automatic t_self;
		// unchained self loop: repeats, then stops
		dsc(32'h0000_01C0, 32'h0004_0000, 32'h0000_0420,
			32'h0000_0530, 32'h0000_0002);
		wr(DDS_OFF_REPEAT, 32'h0000_0001);
		start(32'h0000_01C0);
		wait_idle();
		chk("selfloop", wr_cnt - n0, 32'h0000_0002);
		chk("w530", m(32'h0000_0530), pat(32'h0000_0420));
		rd(DDS_OFF_REPEAT, 32'h0000_0000, "repeat");
		rd(DDS_OFF_STATUS, 32'h0000_0001, "status");
	endtask
	// ----
	// run
	// ----
	initial
	begin
		REF_CLK = 1'b0;
		forever
			#5 REF_CLK = ~REF_CLK;
	end
	always @(posedge REF_CLK)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			err_count++;
			tally_and_finish();
		end
	end
	initial
	begin
		RESETN = 1'b0;
		WR = 1'b0;
		RD = 1'b0;
		ADDR = 8'h00;
		WDATA = 32'h0000_0000;
		EVENT_SET = 8'h00;
		ack_delay = 4'h0;
		repeat (10) @(posedge REF_CLK);
		RESETN <= 1'b1;
		t_reset();
		t_link();
		t_loop();
		t_sync();
		t_event();
		t_self();
		tally_and_finish();
	end
endmodule
